// ==== rtl/sirq_flag.sv ====
/*
 * sirq_flag: one status flag with set-beats-clear priority.
 * Assumes clear is a single-cycle pulse on the block clock; set may be a held level, as for the fault flag.
 */
`timescale 1ns/1ps
`default_nettype none
module sirq_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    // set wins so a coincident event is never lost
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag <= RST_VAL;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end
endmodule : sirq_flag
`default_nettype wire

// ==== rtl/sirq_pkg.sv ====
/*
 * sirq_pkg: register map, field positions, reset values and bus structs
 * for the serial interface interrupt request and flag-clearing block.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
package sirq_pkg;
    // register byte offsets
    localparam logic [7:0] SIRQ_OFF_CTRL = 8'h00;     // control_register
    localparam logic [7:0] SIRQ_OFF_STAT = 8'h04;     // status_control_register
    localparam logic [7:0] SIRQ_OFF_DATA = 8'h08;     // data_register
    localparam logic [7:0] SIRQ_OFF_ISTAT = 8'h0c;    // sticky event status
    localparam logic [7:0] SIRQ_OFF_IMASK = 8'h10;    // event mask
    // control field positions
    localparam int SIRQ_CTL_ENABLE = 0;               // module_enable_bit
    localparam int SIRQ_CTL_TXIE = 1;                 // tx_irq_enable
    localparam int SIRQ_CTL_RXIE = 2;                 // rx_irq_enable
    localparam int SIRQ_CTL_ERROR_IRQ_ENABLE = 3;                // error_irq_enable
    localparam int SIRQ_CTL_MASTER = 4;               // master select
    localparam int SIRQ_CTL_W = 5;
    // status field positions
    localparam int SIRQ_ST_TXE = 0;                   // tx_buffer_empty_flag
    localparam int SIRQ_ST_RXF = 1;                   // rx_full_flag
    localparam int SIRQ_ST_OVR = 2;                   // overrun_flag
    localparam int SIRQ_ST_MODE_FAULT_FLAG = 3;                  // mode_fault_flag
    localparam int SIRQ_ST_W = 4;
    // event bits share the status layout
    localparam int SIRQ_EV_W = 4;
    // reset values
    localparam logic [SIRQ_CTL_W-1:0] SIRQ_CTL_RST = 5'h00;
    localparam logic [SIRQ_ST_W-1:0] SIRQ_ST_RST = 4'h1;   // buffer starts empty
    localparam logic [SIRQ_EV_W-1:0] SIRQ_MASK_RST = 4'h0;
    // data width of the byte buffers
    localparam int SIRQ_DW = 8;

    // avalon request bundle
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } sirq_req_s;

    // shift side handshake into the block
    typedef struct packed {
        logic load_taken;                 // buffer byte moved to shifter
        logic rx_done;                    // byte received
        logic [SIRQ_DW-1:0] rx_byte;      // received byte
        logic fault;                      // mode fault condition level
    } sirq_shift_s;
endpackage : sirq_pkg

// ==== rtl/sirq_top.sv ====
/*
 * sirq_top: interrupt request and flag-clearing logic of a serial
 * interface. Holds control, status, data and event registers on an
 * Avalon-MM slave; combines four flags with enables into three requests.
 * Assumes the shifter runs on the same clock and pulses its events; fault is a held level.
 */
// Notes on behaviour
// - tx request: empty flag, tx enable, module enable
// - rx request: full flag and rx enable only
// - error request: overrun or fault with error enable
// - rx full clears: status read, then data read
// - data write with byte lane 0 clears empty flag only; a load in the same cycle wins
// - fault clears: status read, control write, no fault
// - fault never clears enable nor resets interface
// - empty flag sets when buffer loads shifter
`timescale 1ns/1ps
`default_nettype none
module sirq_top
    import sirq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire sirq_shift_s shift_in,
    output logic [SIRQ_DW-1:0] tx_byte,
    output logic tx_pending,
    output logic module_enable,
    output logic master_mode,
    output logic tx_irq,
    output logic rx_irq,
    output logic err_irq,
    output logic irq
);
    // elaboration check: a narrower bus cannot reach every offset
    if (ADDR_W < 8) begin : g_addr_chk
        $error("sirq_top: ADDR_W must be at least 8");
    end

    // answer states: one wait cycle, then done
    typedef enum logic [0:0] {
        SIRQ_IDLE = 1'b0,
        SIRQ_ACK = 1'b1
    } sirq_bus_e;

    sirq_bus_e bus_r;                          // bus answer state
    logic [SIRQ_CTL_W-1:0] ctrl_r;             // control register
    logic [SIRQ_DW-1:0] tx_buf_r;              // transmit buffer
    logic [SIRQ_DW-1:0] rx_buf_r;              // receive data
    logic [SIRQ_EV_W-1:0] ev_r;                // sticky events
    logic [SIRQ_EV_W-1:0] mask_r;              // event mask
    logic rxf_armed_r;                         // status read saw rx full
    logic mode_fault_flag_armed_r;                        // status read saw fault
    logic [31:0] rdata_nxt;
    logic txe, rxf, ovr, mode_fault_flag;
    logic acc_rd, acc_wr;
    logic rd_stat, rd_data, wr_ctrl, wr_data;
    logic clr_rxf, clr_mode_fault_flag, set_ovr;
    logic [SIRQ_ST_W-1:0] stat_v;
    logic [SIRQ_EV_W-1:0] ev_set;

    // offset match, used for every register decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off)); // upper address bits must be zero
    endfunction : hit

    // the access completes on the ack cycle, when waitrequest is low
    assign acc_rd = (bus_r == SIRQ_ACK) && avs_read;
    assign acc_wr = (bus_r == SIRQ_ACK) && avs_write && avs_byteenable[0];
    assign avs_waitrequest = (avs_read || avs_write) && (bus_r != SIRQ_ACK);
    assign rd_stat = acc_rd && hit(avs_address, SIRQ_OFF_STAT);
    assign rd_data = acc_rd && hit(avs_address, SIRQ_OFF_DATA);
    assign wr_ctrl = acc_wr && hit(avs_address, SIRQ_OFF_CTRL);
    assign wr_data = acc_wr && hit(avs_address, SIRQ_OFF_DATA);

    // bus state: every request waits exactly one cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bus_r <= SIRQ_IDLE;
        end else begin
            case (bus_r)
                SIRQ_IDLE: if (avs_read || avs_write) bus_r <= SIRQ_ACK;
                SIRQ_ACK: bus_r <= SIRQ_IDLE;
                default: bus_r <= SIRQ_IDLE;
            endcase
        end
    end

    // control register; fault has no path here, only software writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= SIRQ_CTL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= avs_writedata[SIRQ_CTL_W-1:0];
        end
    end
    assign module_enable = ctrl_r[SIRQ_CTL_ENABLE];
    assign master_mode = ctrl_r[SIRQ_CTL_MASTER];

    // transmit buffer; pending while the empty flag is low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_buf_r <= '0;
        end else if (wr_data) begin
            tx_buf_r <= avs_writedata[SIRQ_DW-1:0];
        end
    end
    assign tx_byte = tx_buf_r;
    assign tx_pending = !txe;

    // receive data latch; a byte into a full buffer is an overrun
    // and is dropped so the unread byte survives
    assign set_ovr = shift_in.rx_done && rxf && !clr_rxf;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf_r <= '0;
        end else if (shift_in.rx_done && !set_ovr) begin
            rx_buf_r <= shift_in.rx_byte;
        end
    end

    // arming for the two-step clears; any other access keeps the arm
    // so only the ordered pair completes the clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxf_armed_r <= 1'b0;
            mode_fault_flag_armed_r <= 1'b0;
        end else begin
            if (rd_stat) rxf_armed_r <= rxf;
            else if (rd_data) rxf_armed_r <= 1'b0;
            if (rd_stat) mode_fault_flag_armed_r <= mode_fault_flag;
            else if (wr_ctrl || shift_in.fault) mode_fault_flag_armed_r <= 1'b0;
        end
    end
    assign clr_rxf = rd_data && rxf_armed_r;
    // fault still present blocks the clear
    assign clr_mode_fault_flag = wr_ctrl && mode_fault_flag_armed_r && !shift_in.fault;

    // the four status flags, set winning over clear
    sirq_flag #(.RST_VAL(SIRQ_ST_RST[SIRQ_ST_TXE])) u_txe (
        .clock(clock), .reset_n(reset_n),
        .set(shift_in.load_taken),
        .clear(wr_data),
        .flag(txe)
    );
    sirq_flag #(.RST_VAL(SIRQ_ST_RST[SIRQ_ST_RXF])) u_rxf (
        .clock(clock), .reset_n(reset_n),
        .set(shift_in.rx_done), .clear(clr_rxf), .flag(rxf)
    );
    // overrun clears with the same ordered pair as rx full
    sirq_flag #(.RST_VAL(SIRQ_ST_RST[SIRQ_ST_OVR])) u_ovr (
        .clock(clock), .reset_n(reset_n),
        .set(set_ovr), .clear(clr_rxf), .flag(ovr)
    );
    sirq_flag #(.RST_VAL(SIRQ_ST_RST[SIRQ_ST_MODE_FAULT_FLAG])) u_mode_fault_flag (
        .clock(clock), .reset_n(reset_n),
        .set(shift_in.fault && !master_mode), .clear(clr_mode_fault_flag), .flag(mode_fault_flag)
    );

    // request levels, combinational so they drop with the flag
    assign tx_irq = txe && ctrl_r[SIRQ_CTL_TXIE] && module_enable;
    assign rx_irq = rxf && ctrl_r[SIRQ_CTL_RXIE];
    assign err_irq = (ovr || mode_fault_flag) && ctrl_r[SIRQ_CTL_ERROR_IRQ_ENABLE];

    // sticky event register, write one to clear, set wins
    always_comb begin
        ev_set = '0;
        ev_set[SIRQ_ST_TXE] = shift_in.load_taken;
        ev_set[SIRQ_ST_RXF] = shift_in.rx_done;
        ev_set[SIRQ_ST_OVR] = set_ovr;
        ev_set[SIRQ_ST_MODE_FAULT_FLAG] = shift_in.fault && !master_mode;
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ev_r <= '0;
            mask_r <= SIRQ_MASK_RST;
        end else begin
            if (acc_wr && hit(avs_address, SIRQ_OFF_ISTAT)) begin
                ev_r <= (ev_r & ~avs_writedata[SIRQ_EV_W-1:0]) | ev_set;
            end else begin
                ev_r <= ev_r | ev_set;
            end
            if (acc_wr && hit(avs_address, SIRQ_OFF_IMASK)) begin
                mask_r <= avs_writedata[SIRQ_EV_W-1:0];
            end
        end
    end
    assign irq = |(ev_r & mask_r);

    // read mux; unmapped addresses read zero
    always_comb begin
        stat_v = '0;
        stat_v[SIRQ_ST_TXE] = txe;
        stat_v[SIRQ_ST_RXF] = rxf;
        stat_v[SIRQ_ST_OVR] = ovr;
        stat_v[SIRQ_ST_MODE_FAULT_FLAG] = mode_fault_flag;
        rdata_nxt = '0;
        if (hit(avs_address, SIRQ_OFF_CTRL)) rdata_nxt[SIRQ_CTL_W-1:0] = ctrl_r;
        else if (hit(avs_address, SIRQ_OFF_STAT)) rdata_nxt[SIRQ_ST_W-1:0] = stat_v;
        else if (hit(avs_address, SIRQ_OFF_DATA)) rdata_nxt[SIRQ_DW-1:0] = rx_buf_r;
        else if (hit(avs_address, SIRQ_OFF_ISTAT)) rdata_nxt[SIRQ_EV_W-1:0] = ev_r;
        else if (hit(avs_address, SIRQ_OFF_IMASK)) rdata_nxt[SIRQ_EV_W-1:0] = mask_r;
    end
    // read data registered in the wait cycle, valid on the ack cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= '0;
        end else if (avs_read && bus_r == SIRQ_IDLE) begin
            avs_readdata <= rdata_nxt;
        end
    end
endmodule : sirq_top
`default_nettype wire

// ==== test/sirq_shift_model.sv ====
/* sirq_shift_model: stand-in for the shifter; loads the buffer after a
 * short or long wait, passes received bytes, holds the fault level. */
`timescale 1ns/1ps
`default_nettype none
module sirq_shift_model
    import sirq_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic tx_pending,
    input wire logic slow,
    input wire logic rx_go,
    input wire logic [SIRQ_DW-1:0] rx_val,
    input wire logic fault_in,
    output sirq_shift_s shift_out
);
    logic [4:0] cnt_r; // wait before taking the byte
    logic load_r; // one-cycle load pulse
    logic [SIRQ_DW-1:0] last_r; // idle line shows its inverse, never a stale byte
    // take the pending byte once the wait runs out
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 5'h00;
            load_r <= 1'b0;
            last_r <= 8'h00;
        end else begin
            load_r <= tx_pending && !load_r && cnt_r == (slow ? 5'h14 : 5'h01);
            cnt_r <= (tx_pending && !load_r) ? cnt_r + 5'h01 : 5'h00;
            last_r <= rx_go ? rx_val : last_r;
        end
    end
    assign shift_out = '{load_taken: load_r, rx_done: rx_go, rx_byte: rx_go ? rx_val : ~last_r,
                         fault: fault_in};
endmodule : sirq_shift_model
`default_nettype wire

// ==== test/sirq_top_checker.sv ====
/* sirq_top_checker: request and flag assertions on the sirq_top ports.
 * Assumes one clock domain and the async active-low reset of sirq_top. */
`timescale 1ns/1ps
`default_nettype none
module sirq_top_checker
    import sirq_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire sirq_shift_s shift_in,
    input wire logic [SIRQ_DW-1:0] tx_byte,
    input wire logic tx_pending,
    input wire logic module_enable,
    input wire logic master_mode,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic err_irq,
    input wire logic irq
);
    logic acc, cwr, dwr, drd; // accepted access kinds
    assign acc = (avs_read | avs_write) & ~avs_waitrequest;
    assign cwr = acc & avs_write & avs_byteenable[0] & (avs_address == ADDR_W'(SIRQ_OFF_CTRL));
    assign dwr = acc & avs_write & avs_byteenable[0] & (avs_address == ADDR_W'(SIRQ_OFF_DATA));
    assign drd = acc & avs_read & (avs_address == ADDR_W'(SIRQ_OFF_DATA));
    logic flt_hold; // fault present in slave mode, error enable not written off
    assign flt_hold = err_irq & shift_in.fault & ~master_mode & (~cwr | avs_writedata[SIRQ_CTL_ERROR_IRQ_ENABLE]);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_tx_gate: assert property (tx_irq |-> !tx_pending && module_enable) else $error("tx req");
    a_pend_clear: assert property (dwr && !shift_in.load_taken |=> tx_pending) else $error("clr");
    a_pend_set: assert property (shift_in.load_taken |=> !tx_pending) else $error("empty set");
    a_pend_hold: assert property (!dwr && !shift_in.load_taken |=> $stable(tx_pending)) else $error("hold");
    a_enable_kept: assert property (!cwr |=> $stable(module_enable)) else $error("enable moved");
    a_rx_kept: assert property (rx_irq && !cwr && !drd |=> rx_irq) else $error("rx req dropped");
    a_err_kept: assert property (err_irq && !cwr && !drd |=> err_irq) else $error("err dropped");
    a_fault_held: assert property (flt_hold |=> err_irq) else $error("err dropped under fault");
    cover property (drd && rx_irq);
    cover property (cwr && err_irq && shift_in.fault);
    cover property (shift_in.load_taken && tx_irq == 1'b0);
endmodule : sirq_top_checker

bind sirq_top sirq_top_checker #(.ADDR_W(ADDR_W)) chk_u (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .shift_in(shift_in), .tx_byte(tx_byte),
    .tx_pending(tx_pending), .module_enable(module_enable), .master_mode(master_mode),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq), .irq(irq));
`default_nettype wire

// ==== test/sirq_top_tb_top.sv ====
/* sirq_top_tb_top: drives registers over Avalon-MM and the shifter model;
 * reads are checked from a queue at the edge that accepts them. */
`timescale 1ns/1ps
`default_nettype none
module sirq_top_tb_top
    import sirq_pkg::*;
;
    logic clock = 0, reset_n = 0, avs_read = 0, avs_write = 0, slow = 1, rx_go = 0, fault_in = 0;
    logic [7:0] avs_address = 8'h00, rx_val = 8'h00, tx_byte, b1, b2;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, lfsr_r = 32'h5f30a3ae;
    logic [3:0] avs_byteenable = 4'h0;
    logic avs_waitrequest, tx_pending, module_enable, master_mode, tx_irq, rx_irq, err_irq, irq;
    sirq_shift_s shift_in;
    logic [31:0] expq[$]; // expected read data, oldest first
    int n_mismatch = 0, cmp_count = 0;
    always #2.5 clock = ~clock;
    sirq_top dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .shift_in(shift_in), .tx_byte(tx_byte),
        .tx_pending(tx_pending), .module_enable(module_enable), .master_mode(master_mode),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq), .irq(irq));
    sirq_shift_model far_u (.clock(clock), .reset_n(reset_n), .tx_pending(tx_pending),
        .slow(slow), .rx_go(rx_go), .rx_val(rx_val), .fault_in(fault_in), .shift_out(shift_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic give_up;
        n_mismatch++;
        report_and_stop();
    endtask : give_up
    // one request, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        logic ok;
        @(posedge clock);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        ok = 0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge clock);
            ok = (avs_waitrequest === 1'b0);
        end
        if (!ok) give_up();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 1'b0, 32'h0, 4'hf);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask : wr
    task automatic rx(input logic [7:0] b);
        @(posedge clock);
        rx_go <= 1'b1;
        rx_val <= b;
        @(posedge clock);
        rx_go <= 1'b0;
    endtask : rx
    // read data taken at the rising edge where waitrequest is seen low
    always @(posedge clock) begin
        if (avs_read && avs_waitrequest === 1'b0) chk("readdata", expq.size() ? expq.pop_front() : 32'hx, avs_readdata);
    end
    initial begin
        #200us;
        give_up();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(SIRQ_OFF_STAT, 32'(SIRQ_ST_RST));
        rd(SIRQ_OFF_IMASK, 32'(SIRQ_MASK_RST));
        bus(SIRQ_OFF_CTRL, 1'b1, 32'h1f, 4'h0); // refused: no low byte lane
        rd(SIRQ_OFF_CTRL, 32'h0);
        rd(8'h14, 32'h0); // unmapped
        $display("test reset done");
        lfsr_r = lfsr(lfsr_r);
        b1 = lfsr_r[7:0];
        b2 = lfsr_r[15:8];
        wr(SIRQ_OFF_CTRL, 32'h3);
        @(negedge clock); chk("tx_irq", 1, tx_irq);
        wr(SIRQ_OFF_DATA, {24'h0, b1});
        @(negedge clock); chk("tx_pending", 1, tx_pending);
        chk("tx_byte", b1, tx_byte);
        chk("tx_irq", 0, tx_irq);
        for (int i = 0; i < 60 && tx_pending; i++) @(negedge clock);
        if (tx_pending !== 1'b0) give_up();
        chk("tx_irq", 1, tx_irq);
        wr(SIRQ_OFF_CTRL, 32'h2);
        @(negedge clock); chk("tx_irq", 0, tx_irq);
        $display("test transmit done");
        wr(SIRQ_OFF_CTRL, 32'h4);
        rx(b1);
        @(negedge clock); chk("rx_irq", 1, rx_irq);
        rd(SIRQ_OFF_DATA, {24'h0, b1});
        @(negedge clock); chk("rx_irq", 1, rx_irq);
        rd(SIRQ_OFF_STAT, 32'h3);
        rd(SIRQ_OFF_DATA, {24'h0, b1});
        @(negedge clock); chk("rx_irq", 0, rx_irq);
        $display("test receive done");
        wr(SIRQ_OFF_CTRL, 32'h8);
        rx(b1);
        rx(b2);
        @(negedge clock); chk("err_irq", 1, err_irq);
        rd(SIRQ_OFF_STAT, 32'h7);
        rd(SIRQ_OFF_DATA, {24'h0, b1});
        @(negedge clock); chk("err_irq", 0, err_irq);
        $display("test overrun done");
        wr(SIRQ_OFF_CTRL, 32'h9);
        fault_in <= 1'b1;
        repeat (2) @(negedge clock);
        chk("err_irq", 1, err_irq);
        chk("module_enable", 1, module_enable);
        rd(SIRQ_OFF_STAT, 32'h9);
        wr(SIRQ_OFF_CTRL, 32'h9);
        @(negedge clock); chk("err_irq", 1, err_irq);
        @(posedge clock);
        fault_in <= 1'b0;
        rd(SIRQ_OFF_STAT, 32'h9);
        wr(SIRQ_OFF_CTRL, 32'h9);
        @(negedge clock); chk("err_irq", 0, err_irq);
        $display("test mode fault done");
        rd(SIRQ_OFF_ISTAT, 32'hf);
        @(negedge clock); chk("irq", 0, irq);
        wr(SIRQ_OFF_IMASK, 32'h4);
        @(negedge clock); chk("irq", 1, irq);
        wr(SIRQ_OFF_ISTAT, 32'h4);
        @(negedge clock); chk("irq", 0, irq);
        rd(SIRQ_OFF_ISTAT, 32'hb);
        $display("test events done");
        wr(SIRQ_OFF_CTRL, 32'h19);
        fault_in <= 1'b1;
        repeat (2) @(negedge clock);
        chk("master_mode", 1, master_mode);
        chk("err_irq", 0, err_irq);
        chk("module_enable", 1, module_enable);
        rd(SIRQ_OFF_STAT, 32'h1);
        fault_in <= 1'b0;
        rd(SIRQ_OFF_ISTAT, 32'hb);
        $display("test master fault done");
        report_and_stop();
    end
endmodule : sirq_top_tb_top
`default_nettype wire
